// ### parallel_io_ports_bench.sv
`timescale 1ns/10ps
`default_nettype none
module parallel_io_ports_bench;
    localparam logic [15:0] DB = pio_pkg::DATA_BASE;
    localparam logic [15:0] IB = pio_pkg::DIR_BASE;
    localparam logic [15:0] OB = pio_pkg::OD_BASE;
    localparam logic [15:0] VB = pio_pkg::DRV_BASE;
    localparam logic [15:0] TA = pio_pkg::THRESH_ADDR;
    localparam logic [15:0] P5 = pio_pkg::PORT5_DATA_ADDR;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [15:0] port5_in = 16'h0000;
    pio_pkg::pio_pins_type pin_in;
    pio_pkg::pio_pins_type pin_out;
    pio_pkg::pio_pins_type pin_oe;
    pio_pkg::pio_pins_type ext_level = '0;
    pio_pkg::pio_pad_cfg_type pad_cfg;
    int error_cnt = 0;
    int n_tests = 0;
    logic [15:0] r;

    // 250 MHz clock
    always #2 mclk = ~mclk;

    pio_ports u_dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .port5_in(port5_in), .pad_cfg(pad_cfg));
    pio_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

    //////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_cyc

    // one-cycle write strobe
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        rd_reg(a, r);
        chk(r, exp);
    endtask : rd_chk

    //////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(TA, 16'h0000);
        rd_chk(IB + 16'h0008, 16'h0000);
        rd_chk(OB + 16'h0008, 16'h0000);
        rd_chk(pio_pkg::STROBE_DRV_ADDR, 16'h0000);
        chk(pin_oe.p2, 16'h0000);
    endtask : t_reset

    // input pins: write goes to latch only, read and rmw see the pin
    task automatic t_input;
        @(posedge mclk);
        ext_level.p2 <= 16'ha5c3;
        port5_in <= 16'h3c5a;
        wr_reg(DB + 16'h0008, 16'h1234);
        wait_cyc(26);
        rd_chk(DB + 16'h0008, 16'ha5c3);
        chk(pin_oe.p2, 16'h0000);
        wr_reg(P5, 16'h0000);
        rd_chk(P5, 16'h3c5a);
        rd_reg(DB + 16'h0008, r);
        wr_reg(DB + 16'h0008, r ^ 16'h00ff);
        wr_reg(IB + 16'h0008, 16'hffff);
        wait_cyc(3);
        chk(pin_out.p2, 16'ha53c);
        chk(pin_oe.p2, 16'hffff);
    endtask : t_input

    // output pins in open drain, board pulls released lines low
    task automatic t_output;
        @(posedge mclk);
        ext_level.p2 <= 16'h0000;
        wr_reg(OB + 16'h0008, 16'hffff);
        wait_cyc(3);
        chk(pin_oe.p2, ~16'ha53c);
        wait_cyc(26);
        rd_chk(DB + 16'h0008, 16'ha53c);
        rd_reg(DB + 16'h0008, r);
        wr_reg(DB + 16'h0008, r | 16'h0001);
        wait_cyc(3);
        chk(pin_oe.p2, ~16'ha53d);
        rd_chk(OB + 16'h0008, 16'hffff);
        wr_reg(OB, 16'hffff);
        rd_chk(OB, 16'h0000);
        wr_reg(OB + 16'h000c, 16'hffff);
        rd_chk(OB + 16'h000c, 16'h00ff);
        wr_reg(OB + 16'h0008, 16'h0000);
        wait_cyc(3);
        chk(pin_oe.p2, 16'hffff);
    endtask : t_output

    // absent line 14 of port 3, byte halves of port 0, 8-bit port 4
    task automatic t_widths;
        wr_reg(IB + 16'h000a, 16'hffff);
        rd_chk(IB + 16'h000a, 16'hbfff);
        wr_reg(DB + 16'h000a, 16'hffff);
        wait_cyc(3);
        chk(pin_out.p3, 16'hbfff);
        chk(pin_oe.p3, 16'hbfff);
        wr_reg(IB, 16'h00ff);
        wr_reg(DB + 16'h0002, 16'h0055);
        wr_reg(DB, 16'h00aa);
        wait_cyc(3);
        chk({pin_oe.p0h, pin_oe.p0l}, 16'h00ff);
        chk({pin_out.p0h, pin_out.p0l}, 16'h55aa);
        wr_reg(IB + 16'h000c, 16'hffff);
        wr_reg(DB + 16'h000c, 16'h005a);
        wait_cyc(3);
        // port 4 is still open drain here, so its latch ones are released
        chk({pin_oe.p4, pin_out.p4}, 16'ha55a);
        rd_chk(IB + 16'h000c, 16'h00ff);
    endtask : t_widths

    // each threshold bit alone, then all; direction stays untouched
    task automatic t_thresh;
        for (int i = 0; i < 8; i++) begin
            wr_reg(TA, 16'h0001 << i);
            rd_chk(TA, (16'h0001 << i) & 16'h00df);
        end
        wr_reg(TA, 16'hffff);
        rd_chk(TA, 16'h00df);
        chk({8'h00, pad_cfg.thresh_sel}, 16'h00df);
        chk(pin_oe.p2, 16'hffff);
        rd_chk(IB + 16'h0008, 16'hffff);
    endtask : t_thresh

    // nibble fields: fast/high, slow/dynamic, fast/low, reserved
    task automatic t_drive;
        wr_reg(VB + 16'h000c, 16'hffff);
        rd_chk(VB + 16'h000c, 16'h00ff);
        wr_reg(VB + 16'h0008, 16'hf850);
        rd_chk(VB + 16'h0008, 16'hf850);
        chk(pad_cfg.port_cfg[4], 16'hf850);
        wr_reg(pio_pkg::STROBE_DRV_ADDR, 16'hffff);
        rd_chk(pio_pkg::STROBE_DRV_ADDR, 16'h00ff);
        chk({8'h00, pad_cfg.strobe_cfg}, 16'h00ff);
        rd_chk(16'h0000, 16'h0000);
    endtask : t_drive

    //////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        wait_cyc(20);
        rstn <= 1'b1;
        wait_cyc(1);
        t_reset();
        t_input();
        t_output();
        t_widths();
        t_thresh();
        t_drive();
        give_verdict();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        wait_cyc(5000);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule : parallel_io_ports_bench
`default_nettype wire

// ### pio_board.sv
`timescale 1ns/10ps
`default_nettype none
module pio_board (
    // pins from the block
    input wire pio_pkg::pio_pins_type pin_out,
    input wire pio_pkg::pio_pins_type pin_oe,
    // level of a released line, pull-up or external source
    input wire pio_pkg::pio_pins_type ext_level,
    // level seen back at the block
    output pio_pkg::pio_pins_type pin_in
);
    // released lines take the board level, so a stale drive never shows
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pio_board
`default_nettype wire

// ### pio_pin_group.sv
`timescale 1ns/10ps
`default_nettype none
module pio_pin_group #(
    parameter logic [15:0] PIN_MASK = 16'hffff,
    parameter logic [15:0] OD_MASK = 16'h0000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register side
    input wire logic sample_en,
    input wire logic wr_data,
    input wire logic wr_dir,
    input wire logic wr_od,
    input wire logic [15:0] wdata,
    output logic [15:0] rd_value,
    output logic [15:0] dir,
    output logic [15:0] od,
    // pin side
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe
);

    logic [15:0] latch;
    logic [15:0] in_latch;

    // output latch takes every write, whatever the direction
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            latch <= pio_pkg::LATCH_RESET;
        end else if (wr_data) begin
            latch <= wdata & PIN_MASK;
        end
    end

    // direction resets to input so nothing drives after reset
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dir <= pio_pkg::DIR_RESET;
        end else if (wr_dir) begin
            dir <= wdata & PIN_MASK;
        end
    end

    // open-drain select, inert where the group has none
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            od <= pio_pkg::OD_RESET;
        end else if (wr_od) begin
            od <= wdata & OD_MASK;
        end
    end

    // pin level sampled once per state time in either direction
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            in_latch <= 16'h0000;
        end else if (sample_en) begin
            in_latch <= pin_in & PIN_MASK;
        end
    end

    // drivers: open-drain lets go of a one, push-pull drives both
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_out <= 16'h0000;
            pin_oe <= 16'h0000;
        end else begin
            pin_out <= latch;
            pin_oe <= dir & ~(od & latch);
        end
    end

    // read source: latch for outputs, sampled pin for inputs
    assign rd_value = (dir & latch) | (~dir & in_latch);

endmodule : pio_pin_group
`default_nettype wire

// ### pio_pkg.sv
// How it works
// - port 0 and 1 split into bytes
// - port 2 sixteen bits, ports 4,6,7,8 eight
// - port 3 line 14 absent, bits inert
// - port 5 sixteen-bit input only
// - open-drain select per pin, six ports
// - every pin sampled each state time
// - input pin: write latch, read pin
// - input pin rmw: pin source, latch target
// - direction one enables driver from latch
// - output pin read returns latch
// - output pin rmw: latch source and target
// - open-drain bit resets zero, push-pull
// - open-drain registers in extended area
// - threshold select per byte
// - threshold register bit layout fixed
// - zero ttl levels, one hysteresis levels
// - threshold never alters direction or mode
// - driver config registers plus strobe register
// - nibble edge and drive two-bit fields
// - 8-bit port driver config high byte zero
`default_nettype none
package pio_pkg;

    //////////////////////////////////////////////////////////////////////
    // group index: 0 p0l, 1 p0h, 2 p1l, 3 p1h, 4 p2, 5 p3, 6 p4, 7 p6, 8 p7, 9 p8
    localparam int NGROUP = 10;

    // register addresses, one 16-bit register per even address
    localparam logic [15:0] DATA_BASE = 16'hff00;
    localparam logic [15:0] DIR_BASE = 16'hff40;
    localparam logic [15:0] OD_BASE = 16'hf100;
    localparam logic [15:0] DRV_BASE = 16'hf080;
    localparam logic [15:0] STROBE_DRV_ADDR = 16'hf0aa;
    localparam logic [15:0] THRESH_ADDR = 16'hf1c4;
    localparam logic [15:0] PORT5_DATA_ADDR = 16'hff20;
    localparam logic [15:0] ADDR_STEP = 16'h0002;

    // implemented pin lines per group
    localparam logic [NGROUP-1:0][15:0] PIN_MASK = {
        16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hbfff,
        16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
    // open-drain capable lines per group
    localparam logic [NGROUP-1:0][15:0] OD_MASK = {
        16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hbfff,
        16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    // driver config bits per group, 8-bit groups have two nibbles
    localparam logic [NGROUP-1:0][15:0] DRV_MASK = {
        16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hffff,
        16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
    localparam logic [15:0] PORT5_MASK = 16'hffff;

    // threshold select bit positions
    localparam int THR_P2L = 0;
    localparam int THR_P2H = 1;
    localparam int THR_P3L = 2;
    localparam int THR_P3H = 3;
    localparam int THR_P4 = 4;
    localparam int THR_P7 = 6;
    localparam int THR_P8 = 7;
    localparam logic [7:0] THRESH_MASK = 8'hdf;
    localparam logic [7:0] THRESH_RESET = 8'h00;

    // nibble field layout in a driver config register
    localparam int NIB_EDGE_LSB = 0;
    localparam int NIB_DRIVE_LSB = 2;
    localparam int NIB_BITS = 4;
    localparam logic [1:0] EDGE_FAST = 2'h0;
    localparam logic [1:0] EDGE_SLOW = 2'h1;
    localparam logic [1:0] DRIVE_HIGH = 2'h0;
    localparam logic [1:0] DRIVE_DYNAMIC = 2'h1;
    localparam logic [1:0] DRIVE_LOW = 2'h2;
    localparam logic [15:0] DRV_RESET = 16'h0000;
    localparam logic [7:0] STROBE_DRV_RESET = 8'h00;

    // reset values of the pin group registers
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam logic [15:0] DIR_RESET = 16'h0000;
    localparam logic [15:0] OD_RESET = 16'h0000;

    // state time sampling rate
    localparam int CLK_MHZ = 250;
    localparam int STATE_TIME_NS = 50;
    localparam int STATE_CYCLES = (STATE_TIME_NS * CLK_MHZ) / 1000;
    localparam int DIV_W = 8;

    //////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] p0l;
        logic [7:0] p0h;
        logic [7:0] p1l;
        logic [7:0] p1h;
        logic [15:0] p2;
        logic [15:0] p3;
        logic [7:0] p4;
        logic [7:0] p6;
        logic [7:0] p7;
        logic [7:0] p8;
    } pio_pins_type;

    typedef struct packed {
        logic [NGROUP-1:0][15:0] port_cfg;
        logic [7:0] strobe_cfg;
        logic [7:0] thresh_sel;
    } pio_pad_cfg_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pio_bus_req_type;

endpackage : pio_pkg
`default_nettype wire

// ### pio_ports.sv
`timescale 1ns/10ps
`default_nettype none
module pio_ports (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // pins of the bidirectional groups
    input wire pio_pkg::pio_pins_type pin_in,
    output pio_pkg::pio_pins_type pin_out,
    output pio_pkg::pio_pins_type pin_oe,
    // input-only port 5
    input wire logic [15:0] port5_in,
    // pad configuration toward the drivers and receivers
    output pio_pkg::pio_pad_cfg_type pad_cfg
);

    //////////////////////////////////////////////////////////////////////
    // internal per-group wiring, every group held sixteen bits wide

    logic [pio_pkg::NGROUP-1:0][15:0] grp_in;
    logic [pio_pkg::NGROUP-1:0][15:0] grp_out;
    logic [pio_pkg::NGROUP-1:0][15:0] grp_oe;
    logic [pio_pkg::NGROUP-1:0][15:0] grp_rd;
    logic [pio_pkg::NGROUP-1:0][15:0] grp_dir;
    logic [pio_pkg::NGROUP-1:0][15:0] grp_od;
    logic [pio_pkg::NGROUP-1:0] hit_data;
    logic [pio_pkg::NGROUP-1:0] hit_dir;
    logic [pio_pkg::NGROUP-1:0] hit_od;
    logic [pio_pkg::NGROUP-1:0] hit_drv;
    logic hit_strobe;
    logic hit_thresh;
    logic hit_port5;
    logic [pio_pkg::NGROUP-1:0][15:0] drv_cfg;
    logic [7:0] strobe_cfg;
    logic [7:0] thresh_sel;
    logic [15:0] port5_latch;
    logic [pio_pkg::DIV_W-1:0] div_cnt;
    logic sample_en;
    logic [15:0] next_rdata;

    //////////////////////////////////////////////////////////////////////
    // pin bundle to groups; bytes of ports 0 and 1 are separate groups

    assign grp_in[0] = {8'h00, pin_in.p0l};
    assign grp_in[1] = {8'h00, pin_in.p0h};
    assign grp_in[2] = {8'h00, pin_in.p1l};
    assign grp_in[3] = {8'h00, pin_in.p1h};
    assign grp_in[4] = pin_in.p2;
    assign grp_in[5] = pin_in.p3;
    assign grp_in[6] = {8'h00, pin_in.p4};
    assign grp_in[7] = {8'h00, pin_in.p6};
    assign grp_in[8] = {8'h00, pin_in.p7};
    assign grp_in[9] = {8'h00, pin_in.p8};

    // driven values and enables come straight from group flops
    assign pin_out.p0l = grp_out[0][7:0];
    assign pin_out.p0h = grp_out[1][7:0];
    assign pin_out.p1l = grp_out[2][7:0];
    assign pin_out.p1h = grp_out[3][7:0];
    assign pin_out.p2 = grp_out[4];
    assign pin_out.p3 = grp_out[5];
    assign pin_out.p4 = grp_out[6][7:0];
    assign pin_out.p6 = grp_out[7][7:0];
    assign pin_out.p7 = grp_out[8][7:0];
    assign pin_out.p8 = grp_out[9][7:0];

    assign pin_oe.p0l = grp_oe[0][7:0];
    assign pin_oe.p0h = grp_oe[1][7:0];
    assign pin_oe.p1l = grp_oe[2][7:0];
    assign pin_oe.p1h = grp_oe[3][7:0];
    assign pin_oe.p2 = grp_oe[4];
    assign pin_oe.p3 = grp_oe[5];
    assign pin_oe.p4 = grp_oe[6][7:0];
    assign pin_oe.p6 = grp_oe[7][7:0];
    assign pin_oe.p7 = grp_oe[8][7:0];
    assign pin_oe.p8 = grp_oe[9][7:0];

    // configuration toward pads, all held in registers
    assign pad_cfg.port_cfg = drv_cfg;
    assign pad_cfg.strobe_cfg = strobe_cfg;
    assign pad_cfg.thresh_sel = thresh_sel;

    //////////////////////////////////////////////////////////////////////
    // state time divider, one pulse every STATE_CYCLES clocks

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            div_cnt <= '0;
            sample_en <= 1'b0;
        end else if (div_cnt == pio_pkg::DIV_W'(pio_pkg::STATE_CYCLES - 1)) begin
            div_cnt <= '0;
            sample_en <= 1'b1;
        end else begin
            div_cnt <= div_cnt + pio_pkg::DIV_W'(1);
            sample_en <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // address decode

    // one compare per group register, addresses step by two
    always_comb begin
        for (int i = 0; i < pio_pkg::NGROUP; i++) begin
            hit_data[i] = (addr == pio_pkg::DATA_BASE + 16'(i * 2));
            hit_dir[i] = (addr == pio_pkg::DIR_BASE + 16'(i * 2));
            hit_od[i] = (addr == pio_pkg::OD_BASE + 16'(i * 2));
            hit_drv[i] = (addr == pio_pkg::DRV_BASE + 16'(i * 2));
        end
    end

    assign hit_strobe = (addr == pio_pkg::STROBE_DRV_ADDR);
    assign hit_thresh = (addr == pio_pkg::THRESH_ADDR);
    assign hit_port5 = (addr == pio_pkg::PORT5_DATA_ADDR);

    //////////////////////////////////////////////////////////////////////
    // pin groups: data latch, direction, open-drain and input latch

    genvar g;
    generate
        for (g = 0; g < pio_pkg::NGROUP; g++) begin : gen_group
            pio_pin_group #(
                .PIN_MASK(pio_pkg::PIN_MASK[g]),
                .OD_MASK(pio_pkg::OD_MASK[g])
            ) u_group (
                .mclk(mclk),
                .rstn(rstn),
                .sample_en(sample_en),
                .wr_data(wr && hit_data[g]),
                .wr_dir(wr && hit_dir[g]),
                .wr_od(wr && hit_od[g]),
                .wdata(wdata),
                .rd_value(grp_rd[g]),
                .dir(grp_dir[g]),
                .od(grp_od[g]),
                .pin_in(grp_in[g]),
                .pin_out(grp_out[g]),
                .pin_oe(grp_oe[g])
            );
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // port 5: sampled only; writes have nowhere to go

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            port5_latch <= 16'h0000;
        end else if (sample_en) begin
            port5_latch <= port5_in & pio_pkg::PORT5_MASK;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // output driver configuration, nibble fields stored as written

    // reserved field codes are kept, the pad decides what they mean
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            drv_cfg <= '0;
        end else begin
            for (int i = 0; i < pio_pkg::NGROUP; i++) begin
                if (wr && hit_drv[i]) begin
                    drv_cfg[i] <= wdata & pio_pkg::DRV_MASK[i];
                end
            end
        end
    end

    // bus strobe and address-latch lines share one 8-bit register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            strobe_cfg <= pio_pkg::STROBE_DRV_RESET;
        end else if (wr && hit_strobe) begin
            strobe_cfg <= wdata[7:0];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // input threshold select, one bit per byte

    // bit 5 and the high byte are not stored
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            thresh_sel <= pio_pkg::THRESH_RESET;
        end else if (wr && hit_thresh) begin
            thresh_sel <= wdata[7:0] & pio_pkg::THRESH_MASK;
        end
    end
    // threshold only reaches the receivers; group logic never reads it

    //////////////////////////////////////////////////////////////////////
    // read mux, answered one cycle after the strobe

    // a read of a data register is the source half of any rmw
    always_comb begin
        next_rdata = 16'h0000;
        for (int i = 0; i < pio_pkg::NGROUP; i++) begin
            if (hit_data[i]) begin
                next_rdata = grp_rd[i];
            end
            if (hit_dir[i]) begin
                next_rdata = grp_dir[i];
            end
            if (hit_od[i]) begin
                next_rdata = grp_od[i];
            end
            if (hit_drv[i]) begin
                next_rdata = drv_cfg[i];
            end
        end
        if (hit_strobe) begin
            next_rdata = {8'h00, strobe_cfg};
        end
        if (hit_thresh) begin
            next_rdata = {8'h00, thresh_sel};
        end
        if (hit_port5) begin
            next_rdata = port5_latch;
        end
    end

    // data holds only in the cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule : pio_ports
`default_nettype wire

// ### pio_ports_props.sv
`timescale 1ns/10ps
`default_nettype none
module pio_ports_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    // pins and pad settings
    input wire pio_pkg::pio_pins_type pin_out,
    input wire pio_pkg::pio_pins_type pin_oe,
    input wire pio_pkg::pio_pad_cfg_type pad_cfg
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    localparam logic [15:0] DIR4 = pio_pkg::DIR_BASE + 16'h000c;
    localparam logic [15:0] DAT4 = pio_pkg::DATA_BASE + 16'h000c;
    localparam logic [15:0] DRV4 = pio_pkg::DRV_BASE + 16'h000c;

    //////////////////////////////////////////////////////////////////////
    // a write followed by a cycle without overwrite of the same register
    sequence s_dir4;
        wr && addr == DIR4 ##1 !(wr && addr == DIR4);
    endsequence
    sequence s_dat4;
        wr && addr == DAT4 ##1 !(wr && addr == DAT4);
    endsequence

    //////////////////////////////////////////////////////////////////////
    // an open-drain one releases its line, so latch ones are or-ed into both sides
    a_dir_drives_oe: assert property (s_dir4 |=>
        (pin_oe.p4 | pin_out.p4) == ($past(wdata[7:0], 2) | pin_out.p4))
        else $error("port 4 enable does not follow direction write");
    a_dat_drives_out: assert property (s_dat4 |=> pin_out.p4 == $past(wdata[7:0], 2))
        else $error("port 4 output does not follow latch write");
    a_reset_no_drive: assert property ($rose(rstn) |-> pin_oe == '0)
        else $error("pins driven after reset");
    a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data outside the read cycle");
    a_drv_high_zero: assert property (rd && addr == DRV4 |=> rdata[15:8] == 8'h00)
        else $error("8-bit driver config high byte not zero");
    a_thr_read_back: assert property (rd && addr == pio_pkg::THRESH_ADDR |=>
        rdata == {8'h00, $past(pad_cfg.thresh_sel)})
        else $error("threshold read differs from setting");
    a_thr_bit_unused: assert property (pad_cfg.thresh_sel[5] == 1'b0)
        else $error("unused threshold bit set");
    a_thr_only_write: assert property (!$stable(pad_cfg.thresh_sel) |->
        $past(wr && addr == pio_pkg::THRESH_ADDR))
        else $error("threshold changed without write");
    a_strobe_only_wr: assert property ($changed(pad_cfg.strobe_cfg) |->
        $past(wr && addr == pio_pkg::STROBE_DRV_ADDR))
        else $error("strobe config changed without write");
    a_p3_line_dead: assert property (pin_oe.p3[14] == 1'b0 && pin_out.p3[14] == 1'b0)
        else $error("absent port 3 line driven");
endmodule : pio_ports_props

bind pio_ports pio_ports_props u_props (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe), .pad_cfg(pad_cfg));
`default_nettype wire
